// File: bench/tbpwm_load.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// load on the shared pin: measures period and high time
// ------------------------------------------------------------
module tbpwm_load (
  // clock and pin
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pin_o,
  input  wire logic        pin_oe,
  // measurements of the last full period
  output logic      [15:0] rises,
  output logic      [15:0] period,
  output logic      [15:0] high_time
);
  logic        level;    // undriven pin reads as low (pull-down)
  logic        last;     // level one cycle ago
  logic [15:0] run_cnt;  // cycles since last rise
  logic [15:0] hi_cnt;   // high cycles since last rise
  assign level = pin_o & pin_oe;

  // a rise closes one period; the first one after setup is partial
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {last, rises, period, high_time, run_cnt, hi_cnt} <= '0;
    end else begin
      last <= level;
      if (level && !last) begin
        rises     <= rises + 16'h0001;
        period    <= run_cnt;
        high_time <= hi_cnt;
        run_cnt   <= 16'h0001;
        hi_cnt    <= 16'h0001;
      end else begin
        run_cnt <= run_cnt + 16'h0001;
        hi_cnt  <= hi_cnt + {15'h0, level};
      end
    end
  end
endmodule // tbpwm_load

`default_nettype wire

// File: bench/tbpwm_props.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// port checker for the timer pwm block
// ------------------------------------------------------------
module tbpwm_props
  import tbpwm_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave side
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // pin and status
  input  wire logic        shared_output_pin_o,
  input  wire logic        shared_output_pin_oe,
  input  wire logic        gpio_disable,
  input  wire logic        timer_irq_flag,
  input  wire logic        toggle_out_signal
);
  // every check assumes the clock enable is held high
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  localparam logic [11:0] MODE_A = {2'b00, TBPWM_IDX_MODE, 2'b00};  // mode word
  localparam logic [11:0] REF_A  = {2'b00, TBPWM_IDX_REF, 2'b00};   // reference word

  // setup phase, then one wait state, then the answer
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_one_wait;
    !pready ##1 pready;
  endsequence
  // write that clears the run bit, seen at its sample edge
  sequence s_stop_write;
    pready && psel && pwrite && paddr == MODE_A && !pwdata[TBPWM_M_RUN];
  endsequence

  property p_wait;       s_setup |=> s_one_wait; endproperty
  property p_pready_one; pready |=> !pready; endproperty
  property p_idle_rdata; !pready |-> prdata == TBPWM_ZERO32; endproperty
  property p_err;        pslverr |-> pready && prdata == TBPWM_ZERO32; endproperty
  property p_ref_wo;     pready && !pwrite && paddr == REF_A |-> prdata == TBPWM_ZERO32 && !pslverr; endproperty
  property p_pin_gpio;   gpio_disable == shared_output_pin_oe; endproperty
  property p_tog_ovf;    $rose(toggle_out_signal) |-> ##[0:2] timer_irq_flag; endproperty
  property p_stop;       s_stop_write |-> ##[0:2] (!toggle_out_signal && !shared_output_pin_o); endproperty

  a_wait:       assert property (p_wait) else $error("answer not after one wait state");
  a_pready_one: assert property (p_pready_one) else $error("ready longer than one cycle");
  a_idle_rdata: assert property (p_idle_rdata) else $error("read data not zero outside answer");
  a_err:        assert property (p_err) else $error("error without ready or with data");
  a_ref_wo:     assert property (p_ref_wo) else $error("reference word readable");
  a_pin_gpio:   assert property (p_pin_gpio) else $error("gpio disable differs from pin enable");
  a_tog_ovf:    assert property (p_tog_ovf) else $error("toggle rose without overflow");
  a_stop:       assert property (p_stop) else $error("outputs not halted after stop");
endmodule // tbpwm_props

bind tbpwm_top tbpwm_props i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .shared_output_pin_o(shared_output_pin_o), .shared_output_pin_oe(shared_output_pin_oe),
  .gpio_disable(gpio_disable), .timer_irq_flag(timer_irq_flag), .toggle_out_signal(toggle_out_signal)
);

`default_nettype wire

// File: bench/test_timer_buzzer_pwm_output.sv
`timescale 1ns/1ps
`default_nettype none

module test_timer_buzzer_pwm_output;
  import tbpwm_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam logic [11:0] A_MODE = {2'b00, TBPWM_IDX_MODE, 2'b00};
  localparam logic [11:0] A_CNT  = {2'b00, TBPWM_IDX_COUNT, 2'b00};
  localparam logic [11:0] A_REF  = {2'b00, TBPWM_IDX_REF, 2'b00};
  localparam logic [11:0] A_IRQ  = {2'b00, TBPWM_IDX_IRQ, 2'b00};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, external_event_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pin_o, pin_oe, gpio_dis, irq_flag, tog;
  logic [15:0] rises, period, high_time;
  int          fails, samples_checked;

  tbpwm_top i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_event_pin(external_event_pin), .shared_output_pin_o(pin_o),
    .shared_output_pin_oe(pin_oe), .gpio_disable(gpio_dis), .timer_irq_flag(irq_flag),
    .toggle_out_signal(tog));
  tbpwm_load i_load (.pclk(pclk), .presetn(presetn), .pin_o(pin_o), .pin_oe(pin_oe),
    .rises(rises), .period(period), .high_time(high_time));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // apb transfer: request held until ready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    if (n >= 20) begin
      check("apb ready", 32'h0000_0001, 32'h0000_0000);
      summarize();
    end
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, 32'(d), q, e);
  endtask
  // count rising edges of the load, bounded
  task automatic wait_rises(input int k);
    logic [15:0] s;
    int n;
    s = rises;
    n = 0;
    while (int'(rises - s) < k && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 4000) begin
      check("pin rises", 32'(k), 32'(rises - s));
      summarize();
    end
  endtask
  // stop, quiet irq, load values, then start last
  task automatic setup(input logic [7:0] mode, input logic [7:0] cnt, input logic [7:0] rf);
    wr(A_MODE, 8'h00);
    wr(A_IRQ, 8'h00);
    wr(A_MODE, mode & 8'h7C);
    wr(A_CNT, cnt);
    wr(A_REF, rf);
    wr(A_MODE, mode & 8'h7F);
    wr(A_MODE, mode);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic s_regs();
    logic [31:0] q;
    logic        e;
    logic [11:0] al [4] = '{A_MODE, A_CNT, A_REF, A_IRQ};
    foreach (al[i]) begin
      apb(1'b0, al[i], TBPWM_ZERO32, q, e);
      check("reset word", TBPWM_ZERO32, q);
    end
    apb(1'b1, 12'h380, 32'h0000_00FF, q, e);
    check("unmapped err", 32'h0000_0001, 32'(e));
    apb(1'b0, 12'h380, TBPWM_ZERO32, q, e);
    check("unmapped rd", TBPWM_ZERO32, q);
    wr(A_REF, 8'hA5);
    apb(1'b0, A_REF, TBPWM_ZERO32, q, e);
    check("ref readback", TBPWM_ZERO32, q);
    wr(A_MODE, 8'h72);
    apb(1'b0, A_MODE, TBPWM_ZERO32, q, e);
    check("mode readback", 32'h0000_0072, q);
    check("buzzer pin oe", 32'h0000_0001, 32'(pin_oe));
  endtask
  task automatic s_pwm();
    logic [31:0] q;
    logic        e;
    logic [7:0]  mask, r, mode;
    int          n;
    for (int m = 0; m < 4; m++) begin
      n    = (m == 0) ? 256 : (128 >> m);
      mask = 8'(n - 1);
      r    = 8'(n / 4 + 1);
      mode = 8'hF1 | 8'(m << 1);
      setup(mode, 8'h00, r | ~mask);
      wait_rises(3);
      check("pwm period", 32'(2 * n), 32'(period));
      check("pwm high", 32'(2 * r), 32'(high_time));
      check("pwm pin oe", 32'h0000_0001, 32'(gpio_dis));
      check("pwm irq", 32'h0000_0001, 32'(irq_flag));
      apb(1'b0, A_MODE, TBPWM_ZERO32, q, e);
      check("pwm mode", 32'(mode), q);
    end
  endtask
  task automatic s_buzz_stop();
    logic [31:0] q, c;
    logic        e;
    setup(8'hF6, 8'hF0, 8'hF0);
    wait_rises(3);
    check("buzz period", 32'h0000_0040, 32'(period));
    check("buzz high", 32'h0000_0020, 32'(high_time));
    wr(A_MODE, 8'h76);
    repeat (4) @(posedge pclk);
    check("stop toggle", TBPWM_ZERO32, 32'(tog));
    apb(1'b0, A_CNT, TBPWM_ZERO32, c, e);
    repeat (40) @(posedge pclk);
    apb(1'b0, A_CNT, TBPWM_ZERO32, q, e);
    check("held count", c, q);
    wr(A_IRQ, 8'h02);
    apb(1'b0, A_IRQ, TBPWM_ZERO32, q, e);
    check("irq cleared", 32'h0000_0002, q);
  endtask
  task automatic s_count_write();
    setup(8'hF1, 8'h00, 8'h80);
    wait_rises(1);
    repeat (4) @(posedge pclk);
    check("pin high", 32'h0000_0001, 32'(pin_o));
    wr(A_CNT, 8'h90);
    repeat (3) @(posedge pclk);
    check("pin after cnt", TBPWM_ZERO32, 32'(pin_o));
    // new duty only once the flag marks a fresh period
    wr(A_IRQ, 8'h00);
    for (int n = 0; n < 600 && irq_flag !== 1'b1; n++) begin
      @(posedge pclk);
    end
    check("irq before ref", 32'h0000_0001, 32'(irq_flag));
    if (irq_flag !== 1'b1) begin
      summarize();
    end
    wr(A_REF, 8'h40);
    wait_rises(2);
    check("duty after flag", 32'h0000_0080, 32'(high_time));
  endtask
  task automatic s_event();
    logic [31:0] q;
    logic        e;
    setup(8'h88, 8'h00, 8'h00);
    repeat (5) begin
      external_event_pin <= 1'b0;
      repeat (6) @(posedge pclk);
      external_event_pin <= 1'b1;
      repeat (6) @(posedge pclk);
    end
    repeat (8) @(posedge pclk);
    apb(1'b0, A_CNT, TBPWM_ZERO32, q, e);
    check("event count", 32'h0000_0005, q);
  endtask

  // ------------------------------------------------------------
  // clock, reset and sequence
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    external_event_pin = 1'b1;
    fails = 0;
    samples_checked = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    s_pwm();
    s_buzz_stop();
    s_count_write();
    s_event();
    summarize();
  end
endmodule // test_timer_buzzer_pwm_output

`default_nettype wire

// File: core/tbpwm_pkg.sv
package tbpwm_pkg;

  // ------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ------------------------------------------------------------
  localparam logic [7:0]  TBPWM_IDX_MODE   = 8'hDC;     // timer_mode_reg
  localparam logic [7:0]  TBPWM_IDX_COUNT  = 8'hDD;     // timer_count
  localparam logic [7:0]  TBPWM_IDX_REF    = 8'hDE;     // timer_reference, write-only
  localparam logic [7:0]  TBPWM_IDX_IRQ    = 8'hDF;     // irq enable / flag
  localparam int          TBPWM_ADDR_LSB   = 2;         // word aligned
  localparam int          TBPWM_ADDR_W     = 12;        // decoded address bits

  // ------------------------------------------------------------
  // mode register fields
  // ------------------------------------------------------------
  localparam int          TBPWM_M_PWM_OE   = 0;         // pwm_out_enable
  localparam int          TBPWM_M_TOG_OE   = 1;         // toggle_out_enable
  localparam int          TBPWM_M_ALOAD    = 2;         // auto_reload_select
  localparam int          TBPWM_M_CKS      = 3;         // clock_source_select
  localparam int          TBPWM_M_RATE_LO  = 4;         // prescale_select low bit
  localparam int          TBPWM_M_RATE_HI  = 6;         // prescale_select high bit
  localparam int          TBPWM_M_RUN      = 7;         // timer_run_enable
  localparam logic [7:0]  TBPWM_MODE_RST   = 8'h00;

  // ------------------------------------------------------------
  // irq register fields
  // ------------------------------------------------------------
  localparam int          TBPWM_I_FLAG     = 0;         // timer_irq_flag
  localparam int          TBPWM_I_EN       = 1;         // timer_irq_enable

  // ------------------------------------------------------------
  // period masks per {auto_reload_select, toggle_out_enable}
  // ------------------------------------------------------------
  localparam logic [7:0]  TBPWM_MASK_256   = 8'hFF;
  localparam logic [7:0]  TBPWM_MASK_64    = 8'h3F;
  localparam logic [7:0]  TBPWM_MASK_32    = 8'h1F;
  localparam logic [7:0]  TBPWM_MASK_16    = 8'h0F;
  localparam logic [7:0]  TBPWM_ZERO8      = 8'h00;
  localparam logic [31:0] TBPWM_ZERO32     = 32'h0000_0000;

  // ------------------------------------------------------------
  // prescaler: code 0 divides by 256, code 7 by 2
  // ------------------------------------------------------------
  localparam int          TBPWM_PRE_W      = 8;
  localparam logic [2:0]  TBPWM_RATE_MAX   = 3'h7;

endpackage : tbpwm_pkg

// File: core/tbpwm_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

module tbpwm_prescaler
  import tbpwm_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  // control
  input  wire logic [2:0] rate,     // prescale_select
  // tick out
  output logic            tick      // one-cycle pulse per divided period
);

  // ------------------------------------------------------------
  // free-running divider
  // ------------------------------------------------------------
  logic [TBPWM_PRE_W-1:0] div_cnt;  // free counter
  logic [TBPWM_PRE_W-1:0] low_mask; // bits that must be all ones
  logic [2:0]             shift;    // how far the mask is narrowed

  // divisor 256 >> rate: the low (8 - rate) bits are all ones once per period
  always_comb begin
    shift    = rate;
    low_mask = TBPWM_MASK_256 >> shift;
  end

  // divider keeps running, so a rate change takes effect without restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= TBPWM_ZERO8;
      tick    <= 1'b0;
    end else if (ce) begin
      div_cnt <= div_cnt + 8'h01;
      tick    <= ((div_cnt & low_mask) == low_mask);
    end
  end

endmodule // tbpwm_prescaler

`default_nettype wire

// File: core/tbpwm_top.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - buzzer output toggles on every overflow
// - toggle enable drives pin, disables gpio
// - run enable clear stops counter and outputs
// - pwm period 256, 64, 32 or 16
// - pwm output high when counter wraps, if reference live bits nonzero
// - pwm high while count below reference
// - duty equals reference over period length
// - pwm enable drives pin, disables gpio
// - reference is write-only, plain writes only
// - every overflow sets irq flag in pwm
// - counter write changes current duty at once
// - rate select in mode bits six:four
// - overflow with auto-reload loads reference
// - pwm mode always reloads on overflow
// - rate code divides cpu clock 256..2
// - clock source counts external falling edges
module tbpwm_top
  import tbpwm_pkg::*;
(
  // clock, reset, clock enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // external event input
  input  wire logic        external_event_pin,
  // shared output pin
  output logic             shared_output_pin_o,
  output logic             shared_output_pin_oe,
  output logic             gpio_disable,
  // status
  output logic             timer_irq_flag,
  output logic             toggle_out_signal
);

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [7:0] timer_mode_reg;    // run, rate, source, reload, enables
  logic [7:0] timer_count;       // the counter itself
  logic [7:0] timer_reference;   // compare / reload value
  logic       timer_irq_enable;  // kept for software, gates nothing here
  logic       pwm_level;         // raw pwm waveform

  // ------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------
  logic       pwm_out_enable;       // pwm mode
  logic       toggle_out_enable;    // buzzer enable / period select
  logic       auto_reload_select;   // reload / period select
  logic       clock_source_select;  // 1 = external events
  logic       timer_run_enable;     // counter runs
  logic [2:0] prescale_select;      // internal divider code

  assign pwm_out_enable      = timer_mode_reg[TBPWM_M_PWM_OE];
  assign toggle_out_enable   = timer_mode_reg[TBPWM_M_TOG_OE];
  assign auto_reload_select  = timer_mode_reg[TBPWM_M_ALOAD];
  assign clock_source_select = timer_mode_reg[TBPWM_M_CKS];
  assign timer_run_enable    = timer_mode_reg[TBPWM_M_RUN];
  assign prescale_select     = timer_mode_reg[TBPWM_M_RATE_HI:TBPWM_M_RATE_LO];

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic [9:0] word_idx;   // word index of the access
  logic       access;     // access phase, not yet answered
  logic       wr_en;      // write takes effect this edge
  logic       rd_en;      // read data captured this edge
  logic       hit_mode;   // mode register selected
  logic       hit_count;  // counter selected
  logic       hit_ref;    // reference selected
  logic       hit_irq;    // irq register selected
  logic       hit_any;    // any mapped register

  assign word_idx  = paddr[TBPWM_ADDR_W-1:TBPWM_ADDR_LSB];
  assign access    = ce && psel && penable && !pready;
  assign wr_en     = access && pwrite;
  assign rd_en     = access && !pwrite;
  assign hit_mode  = (word_idx == {2'b00, TBPWM_IDX_MODE});
  assign hit_count = (word_idx == {2'b00, TBPWM_IDX_COUNT});
  assign hit_ref   = (word_idx == {2'b00, TBPWM_IDX_REF});
  assign hit_irq   = (word_idx == {2'b00, TBPWM_IDX_IRQ});
  assign hit_any   = hit_mode || hit_count || hit_ref || hit_irq;

  // ------------------------------------------------------------
  // apb answer: one wait state, every output registered
  // ------------------------------------------------------------
  // pready rises one edge into the access phase and drops after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= access;
      pslverr <= access && !hit_any;  // unmapped address answers with error
    end
  end

  // read data; reference reads as zero because it is write-only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= TBPWM_ZERO32;
    end else if (ce) begin
      if (rd_en) begin
        if (hit_mode) begin
          prdata <= {24'h00_0000, timer_mode_reg};
        end else if (hit_count) begin
          prdata <= {24'h00_0000, timer_count};
        end else if (hit_irq) begin
          prdata <= {30'h0, timer_irq_enable, timer_irq_flag};
        end else begin
          prdata <= TBPWM_ZERO32;
        end
      end else begin
        prdata <= TBPWM_ZERO32;
      end
    end
  end

  // ------------------------------------------------------------
  // tick sources
  // ------------------------------------------------------------
  logic pre_tick;   // internal divided clock tick
  logic ext_s1;     // synchroniser stage one
  logic ext_s2;     // synchroniser stage two
  logic ext_s3;     // previous synchronised level
  logic ext_fall;   // falling edge on the event pin
  logic tick;       // selected count tick

  tbpwm_prescaler u_prescaler (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .rate    (prescale_select),
    .tick    (pre_tick)
  );

  // pin is asynchronous: two flops before the edge detector sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1 <= 1'b1;
      ext_s2 <= 1'b1;
      ext_s3 <= 1'b1;
    end else if (ce) begin
      ext_s1 <= external_event_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  assign ext_fall = ext_s3 && !ext_s2;
  // rate code is ignored while counting external events
  assign tick     = timer_run_enable &&
                    (clock_source_select ? ext_fall : pre_tick);

  // ------------------------------------------------------------
  // period and overflow
  // ------------------------------------------------------------
  logic [7:0] period_mask;  // live counter bits
  logic       overflow;     // counter leaves its top value
  logic       reload;       // reference goes into the counter
  logic [7:0] next_count;   // counter after a tick

  // period only shortens in pwm mode; plain timer always uses 256
  always_comb begin
    if (!pwm_out_enable) begin
      period_mask = TBPWM_MASK_256;
    end else begin
      unique case ({auto_reload_select, toggle_out_enable})
        2'b00: period_mask = TBPWM_MASK_256;
        2'b01: period_mask = TBPWM_MASK_64;
        2'b10: period_mask = TBPWM_MASK_32;
        2'b11: period_mask = TBPWM_MASK_16;
      endcase
    end
  end

  assign overflow = tick && ((timer_count & period_mask) == period_mask);
  assign reload   = pwm_out_enable || auto_reload_select;

  // pwm reload keeps only the bits above the period, so the live
  // bits restart at zero and each period opens high when the reference's live bits are nonzero
  always_comb begin
    if (!overflow) begin
      next_count = timer_count + 8'h01;
    end else if (pwm_out_enable) begin
      next_count = timer_reference & ~period_mask;
    end else if (reload) begin
      next_count = timer_reference;
    end else begin
      next_count = TBPWM_ZERO8;
    end
  end

  // ------------------------------------------------------------
  // mode and reference registers
  // ------------------------------------------------------------
  // software is expected to stop the timer before reconfiguring
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_mode_reg <= TBPWM_MODE_RST;
    end else if (ce && wr_en && hit_mode) begin
      timer_mode_reg <= pwdata[7:0];
    end
  end

  // write-only; takes effect at once, so a mid-period write distorts
  // that period unless done just after an overflow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_reference <= TBPWM_ZERO8;
    end else if (ce && wr_en && hit_ref) begin
      timer_reference <= pwdata[7:0];
    end
  end

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  // a software write beats a tick in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count <= TBPWM_ZERO8;
    end else if (ce) begin
      if (wr_en && hit_count) begin
        timer_count <= pwdata[7:0];
      end else if (tick) begin
        timer_count <= next_count;
      end
    end
  end

  // ------------------------------------------------------------
  // irq flag and enable
  // ------------------------------------------------------------
  // overflow sets the flag; a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_irq_flag   <= 1'b0;
      timer_irq_enable <= 1'b0;
    end else if (ce) begin
      if (wr_en && hit_irq) begin
        timer_irq_enable <= pwdata[TBPWM_I_EN];
      end
      if (overflow) begin
        timer_irq_flag <= 1'b1;
      end else if (wr_en && hit_irq) begin
        timer_irq_flag <= pwdata[TBPWM_I_FLAG];
      end
    end
  end

  // ------------------------------------------------------------
  // waveform generators
  // ------------------------------------------------------------
  // buzzer: one toggle per overflow gives half the overflow rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      toggle_out_signal <= 1'b0;
    end else if (ce) begin
      if (!timer_run_enable) begin
        toggle_out_signal <= 1'b0;
      end else if (overflow) begin
        toggle_out_signal <= !toggle_out_signal;
      end
    end
  end

  // pwm: compare is continuous, against the counter value after this edge;
  // with the live bits at zero the level is high unless the reference's live bits are zero
  logic [7:0] cmp_count;  // counter value next cycle

  always_comb begin
    if (wr_en && hit_count) begin
      cmp_count = pwdata[7:0];
    end else if (tick) begin
      cmp_count = next_count;
    end else begin
      cmp_count = timer_count;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_level <= 1'b0;
    end else if (ce) begin
      if (!timer_run_enable) begin
        pwm_level <= 1'b0;
      end else begin
        pwm_level <= ((cmp_count & period_mask) <
                      (timer_reference & period_mask));
      end
    end
  end

  // pin follows the generators one cycle later
  logic next_pwm_src;  // pwm level to the pin
  logic next_tog_src;  // buzzer level to the pin

  assign next_pwm_src = pwm_level;
  assign next_tog_src = toggle_out_signal;

  // ------------------------------------------------------------
  // shared pin mux
  // ------------------------------------------------------------
  // pwm enable wins; buzzer is only valid with pwm enable clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_output_pin_o  <= 1'b0;
      shared_output_pin_oe <= 1'b0;
      gpio_disable         <= 1'b0;
    end else if (ce) begin
      if (pwm_out_enable) begin
        shared_output_pin_o  <= timer_run_enable && ((next_pwm_src));
        shared_output_pin_oe <= 1'b1;
        gpio_disable         <= 1'b1;
      end else if (toggle_out_enable) begin
        shared_output_pin_o  <= timer_run_enable && next_tog_src;
        shared_output_pin_oe <= 1'b1;
        gpio_disable         <= 1'b1;
      end else begin
        shared_output_pin_o  <= 1'b0;
        shared_output_pin_oe <= 1'b0;
        gpio_disable         <= 1'b0;
      end
    end
  end

endmodule // tbpwm_top

`default_nettype wire
